// ### logic/scrb_pkg.sv
// Package of offsets, field positions, reset values and timing for the control bank
`default_nettype none

package scrb_pkg;

    // Register byte offsets on the host register port
    localparam logic [7:0] OFF_EEPROM_CONTROL = 8'h22;
    localparam logic [7:0] OFF_MEMORY_SELFTEST_INFO = 8'h24;
    localparam logic [7:0] OFF_GLOBAL_RESET_CONTROL = 8'h26;
    localparam logic [7:0] OFF_WAKE_FRAME_CONTROL = 8'h2A;

    // eeprom_control fields
    localparam int EEC_DIR_BIT = 5;
    localparam int EEC_SWEN_BIT = 4;
    localparam int EEC_DIN_BIT = 3;
    localparam int EEC_DOUT_BIT = 2;
    localparam int EEC_SK_BIT = 1;
    localparam int EEC_CS_BIT = 0;
    localparam logic [2:0] EEC_PIN_CONTROL_RST = 3'h0;

    // memory_selftest_info fields
    localparam int MBI_TX_DONE_BIT = 12;
    localparam int MBI_TX_FAIL_BIT = 11;
    localparam int MBI_TX_CNT_LSB = 8;
    localparam int MBI_RX_DONE_BIT = 4;
    localparam int MBI_RX_FAIL_BIT = 3;
    localparam int MBI_RX_CNT_LSB = 0;

    // global_reset_control fields
    localparam int GRC_QUEUE_BIT = 1;
    localparam int GRC_GLOBAL_BIT = 0;
    localparam logic [1:0] GRC_RST = 2'h0;

    // wake_frame_control fields
    localparam int WFC_SIG_BIT = 7;
    localparam logic [3:0] WFC_PATTERN_RST = 4'h0;

    // Automatic address load: first EEPROM word and last word index
    localparam logic [5:0] EE_FIRST_WORD = 6'h01;
    localparam logic [1:0] EE_LAST_INDEX = 2'h2;
    localparam logic [2:0] EE_READ_CMD = 3'h6;  // start bit then read opcode
    localparam logic [4:0] EE_CMD_LAST_BIT = 5'h08;
    localparam logic [4:0] EE_DATA_LAST_BIT = 5'h0F;

    // Serial clock timing: least half period of the EEPROM clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int EE_HALF_NS = 1000;
    localparam int EE_HALF_CYC = (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Loader states
    typedef enum logic [2:0] {
        LD_IDLE = 3'b000,
        LD_SELECT = 3'b001,
        LD_CMD = 3'b010,
        LD_DATA = 3'b011,
        LD_GAP = 3'b100
    } scrb_ld_state_e;

endpackage : scrb_pkg

`default_nettype wire

// ### logic/scrb_eeprom_loader.sv
// Serial EEPROM reader that fetches the host address words after reset
`default_nettype none

module scrb_eeprom_loader #(
    parameter int HALF_CYC = scrb_pkg::EE_HALF_CYC
) (
    input wire logic clk_sys_i,        // System clock
    input wire logic rst_i,            // Sync reset, high
    input wire logic start_i,          // Begin a load
    input wire logic din_i,            // EEPROM data pin level
    output logic busy_o,               // Load in progress
    output logic cs_o,                 // Chip select
    output logic sk_o,                 // Serial clock
    output logic dout_o,               // Data toward EEPROM
    output logic doe_o,                // Data pin drive enable
    output logic word_wr_o,            // Address word strobe
    output logic [1:0] word_sel_o,     // 0 low, 1 mid, 2 high
    output logic [15:0] word_data_o    // Address word
);

    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC must lie in 1..255");
    end

    scrb_pkg::scrb_ld_state_e state, next_state;
    logic [7:0] tick_cnt, next_tick_cnt;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [1:0] word_idx, next_word_idx;
    logic [15:0] shreg, next_shreg;
    logic cs, next_cs, sk, next_sk, dout, next_dout;
    logic word_wr, next_word_wr;
    logic tick;

    assign tick = (tick_cnt == 8'h00);

    // Step the serial sequence once per half clock period
    always_comb begin
        next_state = state;
        next_tick_cnt = tick ? 8'(HALF_CYC - 1) : tick_cnt - 8'h01;
        next_bit_cnt = bit_cnt;
        next_word_idx = word_idx;
        next_shreg = shreg;
        next_cs = cs;
        next_sk = sk;
        next_dout = dout;
        next_word_wr = 1'b0;
        unique case (state)
            scrb_pkg::LD_IDLE: begin
                next_tick_cnt = 8'(HALF_CYC - 1);
                if (start_i) begin
                    next_state = scrb_pkg::LD_SELECT;
                    next_word_idx = 2'h0;
                end
            end
            scrb_pkg::LD_SELECT: if (tick) begin
                next_cs = 1'b1;
                next_sk = 1'b0;
                next_bit_cnt = scrb_pkg::EE_CMD_LAST_BIT;
                next_shreg = {scrb_pkg::EE_READ_CMD,
                    scrb_pkg::EE_FIRST_WORD + {4'h0, word_idx}, 7'h00};
                next_dout = scrb_pkg::EE_READ_CMD[2];
                next_state = scrb_pkg::LD_CMD;
            end
            scrb_pkg::LD_CMD: if (tick) begin
                if (!sk) begin
                    next_sk = 1'b1;
                end else begin
                    next_sk = 1'b0;
                    if (bit_cnt == 5'h00) begin
                        next_bit_cnt = scrb_pkg::EE_DATA_LAST_BIT;
                        next_state = scrb_pkg::LD_DATA;
                    end else begin
                        next_bit_cnt = bit_cnt - 5'h01;
                        next_shreg = {shreg[14:0], 1'b0};
                        next_dout = shreg[14];
                    end
                end
            end
            scrb_pkg::LD_DATA: if (tick) begin
                if (!sk) begin
                    next_sk = 1'b1;
                end else begin
                    next_sk = 1'b0;
                    next_shreg = {shreg[14:0], din_i};  // Sample before next rise
                    if (bit_cnt == 5'h00) begin
                        next_word_wr = 1'b1;
                        next_state = scrb_pkg::LD_GAP;
                    end else begin
                        next_bit_cnt = bit_cnt - 5'h01;
                    end
                end
            end
            scrb_pkg::LD_GAP: if (tick) begin
                next_cs = 1'b0;
                if (word_idx == scrb_pkg::EE_LAST_INDEX) begin
                    next_state = scrb_pkg::LD_IDLE;
                end else begin
                    next_word_idx = word_idx + 2'h1;
                    next_state = scrb_pkg::LD_SELECT;
                end
            end
            default: next_state = scrb_pkg::LD_IDLE;
        endcase
    end

    // Loader registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= scrb_pkg::LD_IDLE;
            tick_cnt <= 8'h00;
            bit_cnt <= 5'h00;
            word_idx <= 2'h0;
            shreg <= 16'h0000;
            cs <= 1'b0;
            sk <= 1'b0;
            dout <= 1'b0;
            word_wr <= 1'b0;
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            bit_cnt <= next_bit_cnt;
            word_idx <= next_word_idx;
            shreg <= next_shreg;
            cs <= next_cs;
            sk <= next_sk;
            dout <= next_dout;
            word_wr <= next_word_wr;
        end
    end

    assign busy_o = (state != scrb_pkg::LD_IDLE);
    assign cs_o = cs;
    assign sk_o = sk;
    assign dout_o = dout;
    assign doe_o = (state == scrb_pkg::LD_CMD);
    assign word_wr_o = word_wr;
    assign word_sel_o = word_idx;
    assign word_data_o = shreg;

endmodule : scrb_eeprom_loader

`default_nettype wire

// ### logic/scrb_top.sv
// System control register bank: EEPROM access, self test status, soft resets, wake enables
// Summary of operation
// - EEPROM present: load address after rst_i or global soft reset
// - Access bit 4 hands pins to software
// - Bit 5 write-only: 0 read, 1 write
// - Bit 3 returns live EEPROM data pin
// - Bits 2..0 drive data, clock, select pins
// - Run memory self test after rst_i or global soft reset
// - Transmit test: done 12, fail 11, count 10-8
// - Receive test: done 4, fail 3, count 2-0
// - Queue reset bit 1 flushes queue manager
// - Global reset bit 0 resets whole core
// - Reset bits read-write, active while one
// - Bit 7 enables signature packet detection
// - Bits 3..0 enable wake patterns 3..0
// - Latch data pin at reset as presence
// - Load words 1,2,3 into low, mid, high
`default_nettype none

module scrb_top #(
    parameter int EE_HALF_CYC = scrb_pkg::EE_HALF_CYC
) (
    input wire logic clk_sys_i,                  // System clock
    input wire logic rst_i,                      // Sync reset, high
    input wire logic [7:0] reg_addr_i,           // Register byte address
    input wire logic [1:0] reg_be_i,             // Byte enables
    input wire logic reg_wr_i,                   // Write strobe
    input wire logic reg_rd_i,                   // Read strobe
    input wire logic [15:0] reg_wdata_i,         // Write data
    output logic [15:0] reg_rdata_o,             // Read data
    output logic reg_ack_o,                      // Access done
    input wire logic eeprom_data_pin_i,          // Data pin level
    output logic eeprom_data_pin_o,              // Data pin drive value
    output logic eeprom_data_pin_oe_o,           // Data pin drive enable
    output logic eeprom_clock_pin_o,             // Serial clock pin
    output logic eeprom_select_pin_o,            // Chip select pin
    output logic eeprom_present_o,               // EEPROM fitted
    output logic eeprom_load_busy_o,             // Address load running
    output logic host_addr_wr_o,                 // Address word strobe
    output logic [1:0] host_addr_sel_o,          // 0 low, 1 mid, 2 high
    output logic [15:0] host_addr_data_o,        // Address word
    output logic mem_test_start_o,               // Self test start pulse
    input wire logic tx_mem_test_done_i,         // Transmit test done
    input wire logic tx_mem_test_failed_i,       // Transmit test failed
    input wire logic [2:0] tx_mem_fail_count_i,  // Transmit fail count
    input wire logic rx_mem_test_done_i,         // Receive test done
    input wire logic rx_mem_test_failed_i,       // Receive test failed
    input wire logic [2:0] rx_mem_fail_count_i,  // Receive fail count
    output logic queue_manager_reset_o,          // Queue manager soft reset
    output logic global_reset_o,                 // Core soft reset
    output logic signature_packet_detect_enable_o,  // Signature detect on
    output logic [3:0] wake_pattern_enable_o     // Wake pattern enables
);

    // Word hit on a register offset
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:1] == off[7:1];
    endfunction : reg_hit

    // Control state
    logic [2:0] eeprom_pin_control, next_eeprom_pin_control;
    logic eeprom_sw_access_enable, next_eeprom_sw_access_enable;
    logic eeprom_sw_direction, next_eeprom_sw_direction;
    logic [1:0] grc, next_grc;
    logic signature_packet_detect_enable, next_signature_packet_detect_enable;
    logic [3:0] wake_pattern_enable, next_wake_pattern_enable;
    logic [15:0] selftest_info, next_selftest_info;
    logic eeprom_present, next_eeprom_present;
    logic start, next_start;
    logic [15:0] rdata, next_rdata;
    logic ack, next_ack;
    logic pin_dout, next_pin_dout, pin_doe, next_pin_doe;
    logic pin_sk, next_pin_sk, pin_cs, next_pin_cs;

    // Loader wiring
    logic ld_rst, ld_busy, ld_cs, ld_sk, ld_dout, ld_doe;
    logic wr_lo;

    assign wr_lo = reg_wr_i & reg_be_i[0];
    assign ld_rst = rst_i | grc[scrb_pkg::GRC_GLOBAL_BIT];

    // Automatic address fetch engine
    scrb_eeprom_loader #(
        .HALF_CYC(EE_HALF_CYC)
    ) u_loader (
        .clk_sys_i(clk_sys_i),
        .rst_i(ld_rst),
        .start_i(start & eeprom_present),
        .din_i(eeprom_data_pin_i),
        .busy_o(ld_busy),
        .cs_o(ld_cs),
        .sk_o(ld_sk),
        .dout_o(ld_dout),
        .doe_o(ld_doe),
        .word_wr_o(host_addr_wr_o),
        .word_sel_o(host_addr_sel_o),
        .word_data_o(host_addr_data_o)
    );

    // Register writes, soft reset effects and reset-time capture
    always_comb begin
        next_eeprom_pin_control = eeprom_pin_control;
        next_eeprom_sw_access_enable = eeprom_sw_access_enable;
        next_eeprom_sw_direction = eeprom_sw_direction;
        next_grc = grc;
        next_signature_packet_detect_enable = signature_packet_detect_enable;
        next_wake_pattern_enable = wake_pattern_enable;
        next_eeprom_present = eeprom_present;
        if (wr_lo && reg_hit(reg_addr_i, scrb_pkg::OFF_EEPROM_CONTROL)) begin
            next_eeprom_pin_control = reg_wdata_i[2:0];
            next_eeprom_sw_access_enable = reg_wdata_i[scrb_pkg::EEC_SWEN_BIT];
            next_eeprom_sw_direction = reg_wdata_i[scrb_pkg::EEC_DIR_BIT];
        end
        if (wr_lo && reg_hit(reg_addr_i, scrb_pkg::OFF_GLOBAL_RESET_CONTROL)) begin
            next_grc = reg_wdata_i[1:0];
        end
        if (wr_lo && reg_hit(reg_addr_i, scrb_pkg::OFF_WAKE_FRAME_CONTROL)) begin
            next_signature_packet_detect_enable = reg_wdata_i[scrb_pkg::WFC_SIG_BIT];
            next_wake_pattern_enable = reg_wdata_i[3:0];
        end
        if (grc[scrb_pkg::GRC_GLOBAL_BIT]) begin
            next_eeprom_pin_control = scrb_pkg::EEC_PIN_CONTROL_RST;
            next_eeprom_sw_access_enable = 1'b0;
            next_eeprom_sw_direction = 1'b0;
            next_signature_packet_detect_enable = 1'b0;
            next_wake_pattern_enable = scrb_pkg::WFC_PATTERN_RST;
            next_eeprom_present = eeprom_data_pin_i;
        end
        // Reset completes when the global bit falls
        next_start = grc[scrb_pkg::GRC_GLOBAL_BIT] & ~next_grc[scrb_pkg::GRC_GLOBAL_BIT];
    end

    // Self test status capture, cleared when a new test starts
    always_comb begin
        next_selftest_info = 16'h0000;
        if (!start) begin
            next_selftest_info[scrb_pkg::MBI_TX_DONE_BIT] = tx_mem_test_done_i;
            next_selftest_info[scrb_pkg::MBI_TX_FAIL_BIT] = tx_mem_test_failed_i;
            next_selftest_info[scrb_pkg::MBI_TX_CNT_LSB +: 3] = tx_mem_fail_count_i;
            next_selftest_info[scrb_pkg::MBI_RX_DONE_BIT] = rx_mem_test_done_i;
            next_selftest_info[scrb_pkg::MBI_RX_FAIL_BIT] = rx_mem_test_failed_i;
            next_selftest_info[scrb_pkg::MBI_RX_CNT_LSB +: 3] = rx_mem_fail_count_i;
        end
    end

    // Read data and acknowledge; unmapped offsets read zero
    always_comb begin
        next_ack = reg_rd_i | reg_wr_i;
        next_rdata = 16'h0000;
        if (reg_rd_i) begin
            if (reg_hit(reg_addr_i, scrb_pkg::OFF_EEPROM_CONTROL)) begin
                next_rdata[scrb_pkg::EEC_SWEN_BIT] = eeprom_sw_access_enable;
                next_rdata[scrb_pkg::EEC_DIN_BIT] = eeprom_data_pin_i;
                next_rdata[2:0] = eeprom_pin_control;
            end else if (reg_hit(reg_addr_i, scrb_pkg::OFF_MEMORY_SELFTEST_INFO)) begin
                next_rdata = selftest_info;
            end else if (reg_hit(reg_addr_i, scrb_pkg::OFF_GLOBAL_RESET_CONTROL)) begin
                next_rdata[1:0] = grc;
            end else if (reg_hit(reg_addr_i, scrb_pkg::OFF_WAKE_FRAME_CONTROL)) begin
                next_rdata[scrb_pkg::WFC_SIG_BIT] = signature_packet_detect_enable;
                next_rdata[3:0] = wake_pattern_enable;
            end
            if (!reg_be_i[0]) begin
                next_rdata[7:0] = 8'h00;
            end
            if (!reg_be_i[1]) begin
                next_rdata[15:8] = 8'h00;
            end
        end
    end

    // EEPROM pin ownership
    always_comb begin
        if (eeprom_sw_access_enable) begin
            next_pin_dout = eeprom_pin_control[scrb_pkg::EEC_DOUT_BIT];
            next_pin_sk = eeprom_pin_control[scrb_pkg::EEC_SK_BIT];
            next_pin_cs = eeprom_pin_control[scrb_pkg::EEC_CS_BIT];
            next_pin_doe = eeprom_sw_direction;
        end else begin
            next_pin_dout = ld_dout;
            next_pin_sk = ld_sk;
            next_pin_cs = ld_cs;
            next_pin_doe = ld_doe;
        end
    end

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            eeprom_pin_control <= scrb_pkg::EEC_PIN_CONTROL_RST;
            eeprom_sw_access_enable <= 1'b0;
            eeprom_sw_direction <= 1'b0;
            grc <= scrb_pkg::GRC_RST;
            signature_packet_detect_enable <= 1'b0;
            wake_pattern_enable <= scrb_pkg::WFC_PATTERN_RST;
            selftest_info <= 16'h0000;
            eeprom_present <= eeprom_data_pin_i;
            start <= 1'b1;
            rdata <= 16'h0000;
            ack <= 1'b0;
            pin_dout <= 1'b0;
            pin_doe <= 1'b0;
            pin_sk <= 1'b0;
            pin_cs <= 1'b0;
        end else begin
            eeprom_pin_control <= next_eeprom_pin_control;
            eeprom_sw_access_enable <= next_eeprom_sw_access_enable;
            eeprom_sw_direction <= next_eeprom_sw_direction;
            grc <= next_grc;
            signature_packet_detect_enable <= next_signature_packet_detect_enable;
            wake_pattern_enable <= next_wake_pattern_enable;
            selftest_info <= next_selftest_info;
            eeprom_present <= next_eeprom_present;
            start <= next_start;
            rdata <= next_rdata;
            ack <= next_ack;
            pin_dout <= next_pin_dout;
            pin_doe <= next_pin_doe;
            pin_sk <= next_pin_sk;
            pin_cs <= next_pin_cs;
        end
    end

    // Outputs
    assign reg_rdata_o = rdata;
    assign reg_ack_o = ack;
    assign eeprom_data_pin_o = pin_dout;
    assign eeprom_data_pin_oe_o = pin_doe;
    assign eeprom_clock_pin_o = pin_sk;
    assign eeprom_select_pin_o = pin_cs;
    assign eeprom_present_o = eeprom_present;
    assign eeprom_load_busy_o = ld_busy;
    assign mem_test_start_o = start;
    assign queue_manager_reset_o = grc[scrb_pkg::GRC_QUEUE_BIT];
    assign global_reset_o = grc[scrb_pkg::GRC_GLOBAL_BIT];
    assign signature_packet_detect_enable_o = signature_packet_detect_enable;
    assign wake_pattern_enable_o = wake_pattern_enable;

endmodule : scrb_top

`default_nettype wire

// ### tb/scrb_checker.sv
// Concurrent checks on the control bank ports
`default_nettype none

module scrb_checker #(
    parameter int EE_HALF_CYC = scrb_pkg::EE_HALF_CYC
) (
    input wire logic clk_sys_i,  // System clock
    input wire logic rst_i,  // Sync reset, high
    input wire logic reg_wr_i,  // Write strobe
    input wire logic reg_rd_i,  // Read strobe
    input wire logic [15:0] reg_rdata_o,  // Read data
    input wire logic reg_ack_o,  // Access done
    input wire logic eeprom_data_pin_i,  // Data pin level
    input wire logic eeprom_present_o,  // EEPROM fitted
    input wire logic eeprom_load_busy_o,  // Load running
    input wire logic host_addr_wr_o,  // Address word strobe
    input wire logic [1:0] host_addr_sel_o,  // Word index
    input wire logic mem_test_start_o,  // Self test start
    input wire logic global_reset_o,  // Core soft reset
    input wire logic signature_packet_detect_enable_o,  // Signature enable
    input wire logic [3:0] wake_pattern_enable_o  // Pattern enables
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Register port answers
    ack_follows_a: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o)
        else $error("ack missing after strobe");
    ack_cause_a: assert property (reg_ack_o |-> $past(reg_rd_i || reg_wr_i))
        else $error("ack without strobe");
    rdata_idle_a: assert property (!reg_ack_o |-> reg_rdata_o == 16'h0000)
        else $error("read data outside ack");
    // Self test start after reset release, wake enables cleared in soft reset
    test_start_a: assert property ($fell(rst_i) |-> mem_test_start_o)
        else $error("no self test start after reset");
    test_pulse_a: assert property (!rst_i && mem_test_start_o |=> !mem_test_start_o)
        else $error("self test start too long");
    soft_restart_a: assert property ($fell(global_reset_o) |-> ##[0:2] mem_test_start_o)
        else $error("no self test after soft reset");
    soft_clear_a: assert property (global_reset_o [*3] |->
        !signature_packet_detect_enable_o && wake_pattern_enable_o == 4'h0)
        else $error("wake enables kept in soft reset");
    // Presence latch and address load
    present_latch_a: assert property ($fell(rst_i) |->
        eeprom_present_o == $past(eeprom_data_pin_i))
        else $error("presence not latched");
    load_start_a: assert property ($fell(rst_i) && eeprom_present_o |->
        ##[1:3] eeprom_load_busy_o)
        else $error("address load did not start");
    busy_present_a: assert property (eeprom_load_busy_o |-> eeprom_present_o)
        else $error("load without EEPROM");
    word_strobe_a: assert property (host_addr_wr_o |->
        host_addr_sel_o != 2'h3 ##1 !host_addr_wr_o)
        else $error("bad address word strobe");

    cover property (host_addr_wr_o && host_addr_sel_o == 2'h2);
    cover property ($fell(global_reset_o));
    cover property (reg_ack_o && reg_rdata_o != 16'h0000);
endmodule : scrb_checker

bind scrb_top scrb_checker #(.EE_HALF_CYC(EE_HALF_CYC)) u_scrb_checker (.clk_sys_i,
    .rst_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_ack_o, .eeprom_data_pin_i,
    .eeprom_present_o, .eeprom_load_busy_o, .host_addr_wr_o, .host_addr_sel_o,
    .mem_test_start_o, .global_reset_o, .signature_packet_detect_enable_o,
    .wake_pattern_enable_o);

`default_nettype wire

// ### tb/scrb_eeprom_model.sv
// Behavioural serial EEPROM answering word reads
`default_nettype none

module scrb_eeprom_model (
    input wire logic sk_i,  // Serial clock
    input wire logic cs_i,  // Chip select, high
    input wire logic din_i,  // Line level
    output logic dout_o,  // Read data
    output logic oe_o  // Drives the line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:63];
    logic [5:0] addr;
    int n;

    // Contents: address words at 1..3
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        mem[1] = 16'h89AB;
        mem[2] = 16'h4567;
        mem[3] = 16'h0123;
        n = 0;
        oe_o = 1'b0;
        dout_o = 1'b0;
        addr = 6'h00;
    end

    // Count rises in a frame: 3 command bits, 6 address bits, then 16 data bits
    always @(posedge sk_i or negedge cs_i) begin
        if (!cs_i) begin
            n = 0;
            oe_o = 1'b0;
        end else begin
            n = n + 1;
            if (n >= 4 && n <= 9) addr = {addr[4:0], din_i};
            oe_o = (n >= 10 && n <= 25);
            if (oe_o) dout_o = mem[addr][25 - n];
        end
    end
endmodule : scrb_eeprom_model

`default_nettype wire

// ### tb/test_system_control_register_bank.sv
// Testbench for the system control register bank
`default_nettype none

module test_system_control_register_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [1:0] reg_be_i = 2'h3;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o, host_addr_data_o, rq;
    logic reg_ack_o, eeprom_data_pin_o, eeprom_data_pin_oe_o, eeprom_clock_pin_o;
    logic eeprom_select_pin_o, eeprom_present_o, eeprom_load_busy_o, host_addr_wr_o;
    logic mem_test_start_o, queue_manager_reset_o, global_reset_o, m_d, m_oe;
    logic signature_packet_detect_enable_o;
    logic [1:0] host_addr_sel_o;
    logic [3:0] wake_pattern_enable_o;
    logic [4:0] st_tx = 5'b11101;  // Done, failed, count 5
    logic [4:0] st_rx = 5'b10010;  // Done, passed, count 2
    logic pull = 1'b1;  // Line pull level: high means EEPROM fitted
    logic [15:0] words [0:2];
    int nwords = 0;
    int miscompares = 0;
    int check_count = 0;
    wire logic eeprom_data_pin_i = eeprom_data_pin_oe_o ? eeprom_data_pin_o : (m_oe ? m_d : pull);

    scrb_top #(.EE_HALF_CYC(2)) u_scrb_top (.clk_sys_i, .rst_i, .reg_addr_i, .reg_be_i,
        .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .eeprom_data_pin_i,
        .eeprom_data_pin_o, .eeprom_data_pin_oe_o, .eeprom_clock_pin_o, .eeprom_select_pin_o,
        .eeprom_present_o, .eeprom_load_busy_o, .host_addr_wr_o, .host_addr_sel_o,
        .host_addr_data_o, .mem_test_start_o, .tx_mem_test_done_i(st_tx[4]),
        .tx_mem_test_failed_i(st_tx[3]), .tx_mem_fail_count_i(st_tx[2:0]),
        .rx_mem_test_done_i(st_rx[4]), .rx_mem_test_failed_i(st_rx[3]),
        .rx_mem_fail_count_i(st_rx[2:0]), .queue_manager_reset_o, .global_reset_o,
        .signature_packet_detect_enable_o, .wake_pattern_enable_o);
    scrb_eeprom_model u_scrb_eeprom_model (.sk_i(eeprom_clock_pin_o),
        .cs_i(eeprom_select_pin_o), .din_i(eeprom_data_pin_i), .dout_o(m_d), .oe_o(m_oe));

    always #5 clk_sys_i = ~clk_sys_i;

    // Collect loaded address words
    always @(posedge clk_sys_i) begin
        if (host_addr_wr_o === 1'b1) begin
            words[host_addr_sel_o] <= host_addr_data_o;
            nwords <= nwords + 1;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One strobe cycle, answer sampled after the taking edge
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
        chk({15'h0000, reg_ack_o}, 16'h0001);
        rq = reg_rdata_o;
    endtask : acc

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        chk(rq, exp);
    endtask : rd

    // Pins settle one cycle after the ack
    task automatic pins(input logic [3:0] exp);
        @(posedge clk_sys_i);
        #1;
        chk({12'h000, eeprom_data_pin_oe_o, eeprom_data_pin_o, eeprom_clock_pin_o,
            eeprom_select_pin_o}, {12'h000, exp});
    endtask : pins

    task automatic summarize();
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (600) @(posedge clk_sys_i);
        chk({15'h0000, eeprom_present_o}, 16'h0001);
        chk(16'(nwords), 16'h0003);
        chk(words[0], 16'h89AB);
        chk(words[1], 16'h4567);
        chk(words[2], 16'h0123);
        rd(8'h22, 16'h0008);
        rd(8'h24, 16'h1D12);
        acc(1'b1, 8'h24, 16'h0000);
        rd(8'h24, 16'h1D12);
        rd(8'h26, 16'h0000);
        acc(1'b1, 8'h28, 16'hFFFF);
        rd(8'h28, 16'h0000);
        // Wake enables: reserved bits stay clear
        acc(1'b1, 8'h2A, 16'hFFFF);
        rd(8'h2A, 16'h008F);
        chk({11'h000, signature_packet_detect_enable_o, wake_pattern_enable_o}, 16'h001F);
        acc(1'b1, 8'h2A, 16'h0005);
        rd(8'h2A, 16'h0005);
        chk({12'h000, wake_pattern_enable_o}, 16'h0005);
        // Software pin control, read then write direction
        acc(1'b1, 8'h22, 16'h0017);
        pins(4'b0111);
        rd(8'h22, 16'h001F);
        acc(1'b1, 8'h22, 16'h0034);
        pins(4'b1100);
        rd(8'h22, 16'h001C);
        acc(1'b1, 8'h22, 16'h0030);
        pins(4'b1000);
        rd(8'h22, 16'h0010);
        acc(1'b1, 8'h22, 16'h0007);
        pins(4'b0100);
        rd(8'h22, 16'h000F);
        // Soft resets: raise, check, release
        acc(1'b1, 8'h2A, 16'h0081);
        acc(1'b1, 8'h26, 16'h0001);
        rd(8'h26, 16'h0001);
        chk({14'h0000, global_reset_o, queue_manager_reset_o}, 16'h0002);
        rd(8'h2A, 16'h0000);
        rd(8'h22, 16'h0008);
        acc(1'b1, 8'h26, 16'h0002);
        chk({14'h0000, global_reset_o, queue_manager_reset_o}, 16'h0001);
        acc(1'b1, 8'h26, 16'h0000);
        rd(8'h26, 16'h0000);
        repeat (600) @(posedge clk_sys_i);
        chk(16'(nwords), 16'h0006);
        // No EEPROM fitted: no load after reset
        pull <= 1'b0;
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (600) @(posedge clk_sys_i);
        chk({15'h0000, eeprom_present_o}, 16'h0000);
        chk(16'(nwords), 16'h0006);
        summarize();
    end

    // Watchdog: the sequence needs about 1900 cycles
    initial begin
        repeat (6000) @(posedge clk_sys_i);
        miscompares++;
        summarize();
    end
endmodule : test_system_control_register_bank

`default_nettype wire
